// ==== logic/pgc_gpio_control.sv ====
// Top of the three-pin control block with converter gating and trigger
`default_nettype none
module pgc_gpio_control
    import pgc_pkg::*;
(
    input  wire logic                    sys_clk_in,
    input  wire logic                    nrst_in,
    input  wire pgc_pin_cfg_t [PGC_PINS-1:0] pin_cfg_in,
    input  wire logic [PGC_IRQ_PIN-1:0]  irq_mask_in,
    input  wire logic                    adc_trig_en_in,
    input  wire pgc_buck_cmd_t           host_cmd_in,
    input  wire logic                    read_done_in,
    input  wire logic                    uvlo_in,
    input  wire logic [PGC_PINS-1:0]     pin_in,
    output logic [PGC_PINS-1:0]          pin_out,
    output logic [PGC_PINS-1:0]          pin_oe_n_out,
    output logic                         int_n_out,
    output logic                         adc_start_out,
    output pgc_buck_cmd_t                buck_mode_out,
    output logic [PGC_PINS-1:0]          pin_level_out
);
    typedef struct packed {
        logic [PGC_PINS-1:0] sync1;
        logic [PGC_PINS-1:0] sync2;
        logic                trig_prev;
        logic                adc_start;
        logic [PGC_PINS-1:0] oe_n;
        logic                int_n;
        pgc_buck_cmd_t       mode;
    } pgc_top_state_t;

    pgc_top_state_t             s_reg;
    pgc_top_state_t             s_next;
    logic [PGC_IRQ_PIN-1:0]     pending;
    pgc_buck_cmd_t              pin_cmd;

    // Level match helper reused for the converter, standby and trigger functions
    function automatic logic pgc_active(input logic level, input logic pol);
        return level == pol;
    endfunction : pgc_active

    genvar g;
    generate
        for (g = 0; g < PGC_IRQ_PIN; g++) begin : g_irq
            pgc_irq_latch u_latch (
                .sys_clk_in  (sys_clk_in),
                .nrst_in     (nrst_in),
                .pin_sync_in (s_reg.sync2[g]), // RQ12
                .enable_in   (pin_cfg_in[g].irq_fn && !pin_cfg_in[g].is_output),
                .rise_sel_in (pin_cfg_in[g].polarity),
                .read_done_in(read_done_in), // RQ19
                .clear_in    (uvlo_in || pin_cfg_in[g].is_output), // RQ17
                .pending_out (pending[g])
            );
        end
    endgenerate

    always_comb begin
        pin_cmd = '0;
        // Functions assumed exclusive; each decodes its own enable
        pin_cmd.buck_first_on  = !pin_cfg_in[0].buck_fn ||
            pgc_active(s_reg.sync2[0], pin_cfg_in[0].polarity); // RQ7 RQ8
        pin_cmd.buck_second_on = !pin_cfg_in[1].buck_fn ||
            pgc_active(s_reg.sync2[1], pin_cfg_in[1].polarity); // RQ7 RQ8
        pin_cmd.standby = !pin_cfg_in[0].standby_fn ||
            pgc_active(s_reg.sync2[0], pin_cfg_in[0].polarity); // RQ9
        if (pin_cfg_in[0].is_output) begin
            pin_cmd.buck_first_on = 1'h1;
            pin_cmd.standby       = 1'h1;
        end
        if (pin_cfg_in[1].is_output) begin
            pin_cmd.buck_second_on = 1'h1;
        end
    end

    always_comb begin
        s_next           = s_reg;
        s_next.sync1     = pin_in;
        s_next.sync2     = s_reg.sync1; // RQ12
        s_next.trig_prev = s_reg.sync2[2];
        // Drive low only when output and level low; otherwise release
        for (int i = 0; i < PGC_PINS; i++) begin
            s_next.oe_n[i] = !(pin_cfg_in[i].is_output && !pin_cfg_in[i].out_level); // RQ1 RQ2
        end
        s_next.adc_start = !pin_cfg_in[2].is_output && adc_trig_en_in &&
            (s_reg.sync2[2] != s_reg.trig_prev) &&
            pgc_active(s_reg.sync2[2], pin_cfg_in[2].polarity); // RQ11
        s_next.int_n = !(|(pending & ~irq_mask_in)); // RQ5 RQ13
        // Converter action needs host and pin agreement
        s_next.mode.buck_first_on  = host_cmd_in.buck_first_on && pin_cmd.buck_first_on; // RQ18
        s_next.mode.buck_second_on = host_cmd_in.buck_second_on && pin_cmd.buck_second_on; // RQ18
        // Standby from pin only when pin one in standby mode
        s_next.mode.standby = host_cmd_in.standby && pin_cfg_in[0].standby_fn &&
            !pin_cfg_in[0].is_output && pin_cmd.standby; // RQ18 RQ9
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '{sync1: '0, sync2: '0, trig_prev: PGC_RST_LOW, adc_start: 1'h0,
                       oe_n: '1, int_n: 1'h1, mode: '0}; // RQ3
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_out       = '0;
    assign pin_oe_n_out  = s_reg.oe_n;
    assign int_n_out     = s_reg.int_n;
    assign adc_start_out = s_reg.adc_start;
    assign buck_mode_out = s_reg.mode;
    assign pin_level_out = s_reg.sync2;

    sequence s_trig_edge;
        !pin_cfg_in[2].is_output && adc_trig_en_in &&
            $changed(s_reg.sync2[2]) && (s_reg.sync2[2] == pin_cfg_in[2].polarity);
    endsequence

    chk_adc_trigger: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ11
        s_trig_edge |=> adc_start_out)
        else $error("trigger edge did not start conversion");
    chk_adc_pulse: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ11
        adc_start_out |=> !adc_start_out)
        else $error("conversion start longer than one cycle");
    chk_output_low: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ2
        (pin_cfg_in[0].is_output && !pin_cfg_in[0].out_level) |=> !pin_oe_n_out[0])
        else $error("output pin not driven low");
    chk_input_release: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ1
        !pin_cfg_in[1].is_output |=> pin_oe_n_out[1])
        else $error("input pin driven");
    chk_mask_blocks: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ5
        (&irq_mask_in) |=> int_n_out)
        else $error("masked interrupt asserted");
    chk_host_off: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ18
        !host_cmd_in.buck_first_on |=> !buck_mode_out.buck_first_on)
        else $error("converter on against host command");
    chk_pin_buck: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ8
        (host_cmd_in.buck_second_on && pin_cfg_in[1].buck_fn && !pin_cfg_in[1].is_output &&
         s_reg.sync2[1] != pin_cfg_in[1].polarity) |=> !buck_mode_out.buck_second_on)
        else $error("converter on with inactive pin level");
    chk_uvlo_clear: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ17
        uvlo_in |=> ##1 int_n_out)
        else $error("interrupt held through undervoltage");
    chk_sync_depth: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ12
        1'b1 |=> ##1 (pin_level_out == $past(pin_in, 2)))
        else $error("pin level not two stages late");
    chk_host_off_second: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ18
        !host_cmd_in.buck_second_on |=> !buck_mode_out.buck_second_on)
        else $error("second converter on against host command");
    chk_pin_first_buck: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ7
        (host_cmd_in.buck_first_on && pin_cfg_in[0].buck_fn && !pin_cfg_in[0].is_output &&
         s_reg.sync2[0] != pin_cfg_in[0].polarity) |=> !buck_mode_out.buck_first_on)
        else $error("first converter on with inactive pin level");
    chk_output_release: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ2
        (pin_cfg_in[2].is_output && pin_cfg_in[2].out_level) |=> pin_oe_n_out[2])
        else $error("output pin not released high");
    chk_outputs_clear_irq: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ17
        (pin_cfg_in[0].is_output && pin_cfg_in[1].is_output) |=> ##1 int_n_out)
        else $error("interrupt held with pins as outputs");
    chk_standby_needs_fn: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ9
        !pin_cfg_in[0].standby_fn |=> !buck_mode_out.standby)
        else $error("standby without pin standby function");
endmodule : pgc_gpio_control
`default_nettype wire

// ==== logic/pgc_pkg.sv ====
// Package of constants and carrier types for the pin control block
// What this block does
// [RQ1] Three open-drain pins, each input or output
// [RQ2] Output pin drives low or releases per level
// [RQ3] Reset leaves every pin input, no function
// [RQ4] Pins one, two interrupt on pin edge
// [RQ5] Interrupt mask suppresses pin interrupt request
// [RQ6] Interrupt edge polarity chosen by setting
// [RQ7] Pins one, two follow level for converters
// [RQ8] Polarity setting picks converter-on pin level
// [RQ9] Pin one level puts both converters standby
// [RQ10] Host enables one input function per pin
// [RQ11] Pin three selected edge starts conversion
// [RQ12] Pin input passes two latches first
// [RQ13] Interrupt output low after first edge
// [RQ14] Read clears only after pin returns
// [RQ15] Release needs two edges then a read
// [RQ16] Extra edges without read change nothing
// [RQ17] Undervoltage or output reconfig deasserts interrupt
// [RQ18] Converter on/standby needs both command sources
// [RQ19] Any completed read counts as clearing read
`default_nettype none
package pgc_pkg;
    localparam int          PGC_PINS    = 3;
    localparam int          PGC_IRQ_PIN = 2;
    localparam logic        PGC_RST_LOW = 1'h0;
    localparam logic [1:0]  PGC_FN_NONE = 2'h0;

    // Per-pin configuration from the host side
    typedef struct packed {
        logic is_output;
        logic out_level;
        logic irq_fn;
        logic buck_fn;
        logic standby_fn;
        logic polarity;
    } pgc_pin_cfg_t;

    // Converter command triple (two converters plus standby) from either source
    typedef struct packed {
        logic buck_first_on;
        logic buck_second_on;
        logic standby;
    } pgc_buck_cmd_t;

    typedef enum logic [2:0] {
        PGC_IDLE   = 3'h1,
        PGC_ARMED  = 3'h2,
        PGC_RETURN = 3'h4
    } pgc_irq_state_t;
endpackage : pgc_pkg
`default_nettype wire

// ==== logic/pgc_irq_latch.sv ====
// Edge-triggered interrupt latch for one pin
`default_nettype none
module pgc_irq_latch
    import pgc_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic nrst_in,
    input  wire logic pin_sync_in,
    input  wire logic enable_in,
    input  wire logic rise_sel_in,
    input  wire logic read_done_in,
    input  wire logic clear_in,
    output logic      pending_out
);
    typedef struct packed {
        pgc_irq_state_t st;
        logic           prev;
    } pgc_latch_state_t;

    pgc_latch_state_t s_reg;
    pgc_latch_state_t s_next;
    logic             sel_edge;
    logic             any_edge;

    always_comb begin
        s_next      = s_reg;
        s_next.prev = pin_sync_in;
        any_edge    = pin_sync_in != s_reg.prev;
        sel_edge    = any_edge && (pin_sync_in == rise_sel_in); // RQ6
        case (s_reg.st)
            PGC_IDLE: begin
                if (enable_in && sel_edge) begin
                    s_next.st = PGC_ARMED; // RQ4 RQ13
                end
            end
            PGC_ARMED: begin
                // Second edge only opens the clear path
                if (any_edge) begin
                    s_next.st = PGC_RETURN; // RQ15
                end
            end
            PGC_RETURN: begin
                if (read_done_in) begin // RQ16
                    s_next.st = PGC_IDLE; // RQ14 RQ15
                end
            end
            default: begin
                s_next.st = PGC_IDLE;
            end
        endcase
        // Further edges in RETURN are ignored until a read
        if (clear_in || !enable_in) begin
            s_next.st = PGC_IDLE; // RQ17
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '{st: PGC_IDLE, prev: PGC_RST_LOW};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pending_out = s_reg.st != PGC_IDLE;

    chk_read_needs_return: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ14
        (s_reg.st == PGC_ARMED && !clear_in && enable_in) |=> pending_out)
        else $error("pending cleared before pin returned");
    chk_edges_no_toggle: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ16
        (s_reg.st == PGC_RETURN && !read_done_in && !clear_in && enable_in) |=> pending_out)
        else $error("pending dropped without read");
    chk_first_edge_sets: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RQ13
        (s_reg.st == PGC_IDLE && enable_in && sel_edge && !clear_in) |=> pending_out)
        else $error("selected edge missed");
endmodule : pgc_irq_latch
`default_nettype wire

// ==== testbench/pgc_pin_driver.sv ====
// Far-side model: external open-drain pin drivers with pull-ups
`default_nettype none
module pgc_pin_driver
    import pgc_pkg::*;
(
    input  wire logic [PGC_PINS-1:0] pin_data_in,
    input  wire logic [PGC_PINS-1:0] pin_oe_n_in,
    input  wire logic [PGC_PINS-1:0] ext_low_in,
    output logic      [PGC_PINS-1:0] pin_wire_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up wins unless either party pulls low
    always_comb begin
        for (int i = 0; i < PGC_PINS; i++) begin
            pin_wire_out[i] = (pin_oe_n_in[i] | pin_data_in[i]) & ~ext_low_in[i];
        end
    end
endmodule : pgc_pin_driver
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the three-pin control block
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb
    import pgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        sys_clk_in, nrst_in, adc_trig_en_in, read_done_in, uvlo_in;
    logic                        int_n_out, adc_start_out, pol;
    pgc_pin_cfg_t [PGC_PINS-1:0] pin_cfg_in;
    logic [PGC_IRQ_PIN-1:0]      irq_mask_in;
    pgc_buck_cmd_t               host_cmd_in, buck_mode_out, exp_buck;
    logic [PGC_PINS-1:0]         ext_low, pin_wire, pin_out, pin_oe_n_out, pin_level_out;
    int                          failures, total_checks, seed, pulses;

    pgc_gpio_control uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .pin_cfg_in(pin_cfg_in),
        .irq_mask_in(irq_mask_in), .adc_trig_en_in(adc_trig_en_in), .host_cmd_in(host_cmd_in),
        .read_done_in(read_done_in), .uvlo_in(uvlo_in), .pin_in(pin_wire), .pin_out(pin_out),
        .pin_oe_n_out(pin_oe_n_out), .int_n_out(int_n_out), .adc_start_out(adc_start_out),
        .buck_mode_out(buck_mode_out), .pin_level_out(pin_level_out));
    pgc_pin_driver drv (.pin_data_in(pin_out), .pin_oe_n_in(pin_oe_n_out), .ext_low_in(ext_low),
        .pin_wire_out(pin_wire));

    initial begin
        sys_clk_in = 1'h0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // All driving happens a fixed 2 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask : step

    task automatic wait_int(input logic e);
        int k;
        k = 0;
        while (int_n_out !== e && k < 8) begin
            step(1);
            k++;
        end
        if (int_n_out !== e) begin
            failures++;
            $display("ERROR int_n_out wait exp %h got %h", e, int_n_out);
            test_done();
        end
    endtask : wait_int

    // Pin without the function leaves the host command alone
    function automatic logic want_on(input logic host, input logic fn, input logic p, input logic lvl);
        return host & (!fn | (lvl == p));
    endfunction : want_on

    initial begin
        seed = 32'hFA1A95C6;
        failures = 0;
        total_checks = 0;
        nrst_in = PGC_RST_LOW;
        pin_cfg_in = '0;
        irq_mask_in = '0;
        adc_trig_en_in = 1'h0;
        host_cmd_in = '0;
        read_done_in = 1'h0;
        uvlo_in = 1'h0;
        ext_low = '0;
        step(3);
        `CHK("oe_n reset", 3'h7, pin_oe_n_out)
        `CHK("int_n reset", 1'h1, int_n_out)
        `CHK("buck reset", 3'h0, buck_mode_out)
        nrst_in = 1'h1;
        step(1);
        for (int r = 0; r < 6; r++) begin
            for (int i = 0; i < PGC_PINS; i++) begin
                pin_cfg_in[i].is_output = 1'h1;
                pin_cfg_in[i].out_level = 1'($random(seed));
            end
            step(3);
            for (int i = 0; i < PGC_PINS; i++) begin
                `CHK("oe_n", pin_cfg_in[i].out_level, pin_oe_n_out[i])
                `CHK("level", pin_cfg_in[i].out_level, pin_level_out[i])
            end
            `CHK("pin_out", 3'h0, pin_out)
        end
        $display("test output mode done");
        for (int q = 0; q < 4; q++) begin
            pin_cfg_in = '0;
            pol = q[0];
            ext_low[q[1]] = pol;
            irq_mask_in = '1;
            step(6);
            pin_cfg_in[q[1]].irq_fn = 1'h1;
            pin_cfg_in[q[1]].polarity = pol;
            step(6);
            ext_low[q[1]] = ~pol;
            step(8);
            `CHK("int_n masked", 1'h1, int_n_out)
            irq_mask_in = '0;
            wait_int(1'h0);
            read_done_in = 1'h1;
            step(1);
            read_done_in = 1'h0;
            step(4);
            `CHK("int_n early read", 1'h0, int_n_out)
            ext_low[q[1]] = pol;
            step(2);
            ext_low[q[1]] = ~pol;
            step(2);
            ext_low[q[1]] = pol;
            step(6);
            `CHK("int_n no read", 1'h0, int_n_out)
            read_done_in = 1'h1;
            step(1);
            read_done_in = 1'h0;
            wait_int(1'h1);
            ext_low[q[1]] = ~pol;
            wait_int(1'h0);
            uvlo_in = q[0];
            pin_cfg_in[q[1]].is_output = ~q[0];
            pin_cfg_in[q[1]].out_level = 1'h1;
            wait_int(1'h1);
            `CHK("int_n cleared", 1'h1, int_n_out)
            uvlo_in = 1'h0;
        end
        $display("test interrupt done");
        pin_cfg_in = '0;
        for (int r = 0; r < 24; r++) begin
            host_cmd_in = 3'($random(seed));
            ext_low[1:0] = 2'($random(seed));
            pin_cfg_in[0].buck_fn = (r % 3 == 1);
            pin_cfg_in[0].standby_fn = (r % 3 == 2);
            pin_cfg_in[1].buck_fn = r[0];
            pin_cfg_in[0].polarity = 1'($random(seed));
            pin_cfg_in[1].polarity = 1'($random(seed));
            step(5);
            exp_buck.buck_first_on = want_on(host_cmd_in.buck_first_on, pin_cfg_in[0].buck_fn,
                pin_cfg_in[0].polarity, ~ext_low[0]);
            exp_buck.buck_second_on = want_on(host_cmd_in.buck_second_on, pin_cfg_in[1].buck_fn,
                pin_cfg_in[1].polarity, ~ext_low[1]);
            exp_buck.standby = host_cmd_in.standby & pin_cfg_in[0].standby_fn
                & (~ext_low[0] == pin_cfg_in[0].polarity);
            `CHK("buck mode", exp_buck, buck_mode_out)
        end
        $display("test converter done");
        pin_cfg_in = '0;
        for (int q = 0; q < 4; q++) begin
            pol = q[0];
            adc_trig_en_in = q[1];
            ext_low[2] = pol;
            pin_cfg_in[2].polarity = pol;
            step(6);
            pulses = 0;
            ext_low[2] = ~pol;
            for (int c = 0; c < 16; c++) begin
                if (c == 8) ext_low[2] = pol;
                step(1);
                if (adc_start_out === 1'h1) pulses++;
            end
            `CHK("adc pulses", q[1] ? 1 : 0, pulses)
        end
        $display("test trigger done");
        test_done();
    end
endmodule : tb
`default_nettype wire
